// [saalu_pkg.sv]
/*
  Constants of the pair-SAD and select datapath and its register map.
  Assumes nothing; every design file imports it whole.
*/
package saalu_pkg;

  // ----------------------------------------------------------------------
  // Lane geometry
  // ----------------------------------------------------------------------
  localparam int NCH = 8;
  localparam int LANE_W = 32;
  localparam int DST_W = 16;
  localparam int GUARD_W = 6;
  localparam int ACC_W = DST_W + GUARD_W;
  localparam int SAD_ROUNDS = 64;
  localparam int CNT_W = 8;
  localparam int ESZ_W = 4;

  // ----------------------------------------------------------------------
  // Opcodes and condition modifiers
  // ----------------------------------------------------------------------
  localparam logic [6:0] OPC_PAIR_SAD_ACC = 7'h51;
  localparam logic [6:0] OPC_SELECT = 7'h02;
  localparam logic [3:0] CMOD_NONE = 4'h0;
  localparam logic [3:0] CMOD_EQUAL = 4'h1;
  localparam logic [3:0] CMOD_NOT_EQUAL = 4'h2;
  localparam logic [3:0] CMOD_GREATER = 4'h3;
  localparam logic [3:0] CMOD_GREATER_EQUAL = 4'h4;
  localparam logic [3:0] CMOD_LESS = 4'h5;
  localparam logic [3:0] CMOD_LESS_EQUAL = 4'h6;

  // ----------------------------------------------------------------------
  // Operand type codes and float fields
  // ----------------------------------------------------------------------
  localparam logic [2:0] TY_UD = 3'h0;
  localparam logic [2:0] TY_D = 3'h1;
  localparam logic [2:0] TY_UW = 3'h2;
  localparam logic [2:0] TY_W = 3'h3;
  localparam logic [2:0] TY_UB = 3'h4;
  localparam logic [2:0] TY_B = 3'h5;
  localparam logic [2:0] TY_F = 3'h6;
  localparam int F_SIGN = 31;
  localparam int F_EXP_MSB = 30;
  localparam int F_EXP_LSB = 23;
  localparam int F_MANT_MSB = 22;
  localparam int MOD_NEG_BIT = 0;
  localparam int MOD_ABS_BIT = 1;

  // ----------------------------------------------------------------------
  // Registers (byte offsets on the AHB-Lite slave)
  // ----------------------------------------------------------------------
  localparam int REG_AW = 4;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [REG_AW-1:0] REG_ACC_SEL = 4'h8;
  localparam logic [REG_AW-1:0] REG_ACC_DATA = 4'hc;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STATUS_CNT_LSB = 0;
  localparam int STATUS_GUARD_BIT = 8;
  localparam int ACC_SEL_W = 3;

endpackage

// [saalu_acc_if.sv]
/*
  Datapath to accumulator bank: clear, enables, data and stored values.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface saalu_acc_if;
  import saalu_pkg::*;
  logic clr;
  logic [NCH-1:0] we;
  logic [ACC_W-1:0] wdata [NCH];
  logic [ACC_W-1:0] rdata [NCH];
  modport bank (input clr, input we, input wdata, output rdata);
  modport user (output clr, output we, output wdata, input rdata);
endinterface

// [saalu_acc_bank.sv]
/*
  Accumulator bank: one guarded word per channel, in flip-flops.
  Assumes a synchronous active-low reset and one clock.
*/
`timescale 1ns/1ns
module saalu_acc_bank
  import saalu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Datapath side
  saalu_acc_if.bank acc
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  for (genvar n = 0; n < NCH; n++) begin : g_ent
    logic [ACC_W-1:0] word_r;
    always_ff @(posedge clk) begin
      if (!rst_n || acc.clr) begin
        word_r <= '0;
      end else if (acc.we[n]) begin
        word_r <= acc.wdata[n];
      end
    end
    assign acc.rdata[n] = word_r;
  end

endmodule

// [saalu_top.sv]
/*
  Execution datapath for the pair sum-of-absolute-difference accumulate
  operation and the per-channel select, with an AHB-Lite control slave.
  Assumes operands arrive from issue logic on the same clock, one
  instruction per cycle, and results go to the register file one cycle later.
*/
// The register addresses and the AHB-Lite register port were decided locally.
// Summary of operation
// [RULE1] Opcode 0x51 decodes pair SAD accumulate.
// [RULE2] Even pair: two absolute differences plus accumulator.
// [RULE3] Byte integer sources, word destination, modifiers allowed.
// [RULE4] Result also to accumulator, sixteen bit destination.
// [RULE5] Guard bits survive 64 back-to-back rounds.
// [RULE6] Issuer gives destination stride two, even origin.
// [RULE7] Only even words valid; odd written undefined.
// [RULE8] Issuer never sources the accumulator for SAD.
// [RULE9] Issuer never uses execution size one.
// [RULE10] Opcode 0x02 decodes per-channel select.
// [RULE11] True condition picks first source, else second.
// [RULE12] Predicate selects only, not write enable.
// [RULE13] Issuer supplies predicate when modifier is zero.
// [RULE14] Nonzero modifier compares; flag becomes condition.
// [RULE15] Less and greater-equal use NaN-aware compare.
// [RULE16] NaN-aware: non-NaN wins; both NaN gives NaN.
// [RULE17] Other modifiers pick second source on NaN.
// [RULE18] Modifier flushes denormals; no modifier keeps them.
// [RULE19] Issuer keeps source and destination formats equal.
// [RULE20] Issuer never sources the accumulator for select.
// [RULE21] Issuer never targets the accumulator with select.
// [RULE22] Byte select destination: no unit stride, even origin.
// [RULE23] Disabled channels leave destination and accumulator; odd SAD lanes take zero under the even lane's enable.
`timescale 1ns/1ns
module saalu_top
  import saalu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Instruction issue
  input wire logic iss_valid,
  input wire logic [6:0] iss_opcode,
  input wire logic [3:0] iss_cmod,
  input wire logic [ESZ_W-1:0] iss_exec_size,
  input wire logic [2:0] iss_first_source_type,
  input wire logic [2:0] iss_second_source_type,
  input wire logic [1:0] iss_first_source_mod,
  input wire logic [1:0] iss_second_source_mod,
  input wire logic [NCH*LANE_W-1:0] iss_first_source,
  input wire logic [NCH*LANE_W-1:0] iss_second_source,
  input wire logic [NCH-1:0] iss_chan_en,
  input wire logic iss_pred_on,
  input wire logic [NCH-1:0] iss_pred,
  // Results to the register file
  output logic res_valid,
  output logic [NCH*LANE_W-1:0] res_dst,
  output logic [NCH-1:0] res_channel_write_enable
);

  // ----------------------------------------------------------------------
  // Operand helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] ext32(input logic [31:0] x,
                                        input logic [2:0] ty);
    logic [31:0] v;
    v = x;
    if (ty == TY_UB) begin
      v = {24'h000000, x[7:0]};
    end else if (ty == TY_B) begin
      v = {{24{x[7]}}, x[7:0]};
    end else if (ty == TY_UW) begin
      v = {16'h0000, x[15:0]};
    end else if (ty == TY_W) begin
      v = {{16{x[15]}}, x[15:0]};
    end
    return v;
  endfunction

  // Float modifiers touch only the sign; integer ones act on the value.
  function automatic logic [31:0] apply_mod(input logic [31:0] x,
                                            input logic [2:0] ty,
                                            input logic [1:0] md);
    logic [31:0] v;
    v = ext32(x, ty);
    if (ty == TY_F) begin
      if (md[MOD_ABS_BIT]) begin
        v[F_SIGN] = 1'b0;
      end
      if (md[MOD_NEG_BIT]) begin
        v[F_SIGN] = ~v[F_SIGN];
      end
    end else begin
      if (md[MOD_ABS_BIT] && v[31]) begin
        v = -v;
      end
      if (md[MOD_NEG_BIT]) begin
        v = -v;
      end
    end
    return v;
  endfunction

  // Order key: signed 34-bit, +0 and -0 of a float map to the same key.
  function automatic logic [33:0] order_key(input logic [31:0] v,
                                            input logic [2:0] ty);
    logic [33:0] k;
    k = {{2{v[31]}}, v};
    if (ty == TY_UD || ty == TY_UW || ty == TY_UB) begin
      k = {2'b00, v};
    end else if (ty == TY_F) begin
      k = {3'b000, v[F_EXP_MSB:0]};
      if (v[F_SIGN]) begin
        k = -k;
      end
    end
    return k;
  endfunction

  // ----------------------------------------------------------------------
  // Control state and decode
  // ----------------------------------------------------------------------
  logic ctrl_en_r;
  logic [ACC_SEL_W-1:0] acc_sel_r;
  logic [CNT_W-1:0] round_cnt_r;
  logic guard_r;
  logic ap_wr_r;
  logic [REG_AW-1:0] ap_addr_r;
  logic [31:0] hrdata_r;
  logic res_valid_r;
  logic [LANE_W-1:0] res_dst_r [NCH];
  logic [NCH-1:0] res_we_r;

  saalu_acc_if acc_bus ();

  wire fire = iss_valid & ctrl_en_r;
  wire is_sada = fire & (iss_opcode == OPC_PAIR_SAD_ACC); // RULE1
  wire is_sel = fire & (iss_opcode == OPC_SELECT); // RULE10
  wire cm_on = iss_cmod != CMOD_NONE;
  wire nan_aware = (iss_cmod == CMOD_GREATER_EQUAL) |
                   (iss_cmod == CMOD_LESS); // RULE15
  wire is_flt = iss_first_source_type == TY_F;

  // ----------------------------------------------------------------------
  // Per-channel datapath
  // ----------------------------------------------------------------------
  logic [8:0] abs_diff [NCH];
  logic [NCH-1:0] channel_write_enable_sada;
  logic [NCH-1:0] channel_write_enable_sel;
  logic [LANE_W-1:0] sel_val [NCH];
  logic [LANE_W-1:0] dst_nxt [NCH];
  logic [NCH-1:0] we_nxt;
  logic [NCH-1:0] acc_we;
  logic [ACC_W-1:0] acc_sum [NCH];

  for (genvar n = 0; n < NCH; n++) begin : g_ch
    wire [31:0] a_raw = iss_first_source[n*LANE_W +: LANE_W];
    wire [31:0] b_raw = iss_second_source[n*LANE_W +: LANE_W];
    wire [31:0] a_m = apply_mod(a_raw, iss_first_source_type, iss_first_source_mod);
    wire [31:0] b_m = apply_mod(b_raw, iss_second_source_type, iss_second_source_mod);
    wire in_exec = 5'(n) < {1'b0, iss_exec_size};

    // Byte operands after modifiers span -255..255.
    wire signed [10:0] diff = 11'($signed(a_m[9:0])) -
                              11'($signed(b_m[9:0])); // RULE3
    assign abs_diff[n] = diff[10] ? 9'(-diff) : diff[8:0]; // RULE2

    // Predicate gates the SAD write but never the select write.
    assign channel_write_enable_sada[n] = in_exec & iss_chan_en[n] &
                          (~iss_pred_on | iss_pred[n]);
    assign channel_write_enable_sel[n] = in_exec & iss_chan_en[n]; // RULE12

    wire a_exp0 = a_m[F_EXP_MSB:F_EXP_LSB] == 8'h00;
    wire b_exp0 = b_m[F_EXP_MSB:F_EXP_LSB] == 8'h00;
    wire flush = is_flt & cm_on;
    wire [31:0] a_f = (flush & a_exp0) ? {a_m[F_SIGN], 31'h0} :
                      a_m; // RULE18
    wire [31:0] b_f = (flush & b_exp0) ? {b_m[F_SIGN], 31'h0} :
                      b_m; // RULE18
    wire a_nan = is_flt & (a_m[F_EXP_MSB:F_EXP_LSB] == 8'hff) &
                 (a_m[F_MANT_MSB:0] != 23'h0);
    wire b_nan = is_flt & (b_m[F_EXP_MSB:F_EXP_LSB] == 8'hff) &
                 (b_m[F_MANT_MSB:0] != 23'h0);
    wire [33:0] ka = order_key(a_f, iss_first_source_type);
    wire [33:0] kb = order_key(b_f, iss_first_source_type);
    wire eq = ka == kb;
    wire lt = $signed(ka) < $signed(kb);
    wire gt = $signed(ka) > $signed(kb);
    wire plain_compare = (iss_cmod == CMOD_EQUAL) ? eq :
                         (iss_cmod == CMOD_NOT_EQUAL) ? ~eq :
                         (iss_cmod == CMOD_GREATER) ? gt :
                         (iss_cmod == CMOD_GREATER_EQUAL) ? ~lt :
                         (iss_cmod == CMOD_LESS) ? lt :
                         (iss_cmod == CMOD_LESS_EQUAL) ? ~gt : 1'b0;
    // A lone NaN loses; two NaNs fall to the second source, itself NaN.
    wire nan_aware_compare = (a_nan | b_nan) ? (b_nan & ~a_nan) :
                             plain_compare; // RULE16
    wire cmp_flag = nan_aware ? nan_aware_compare :
                    (~(a_nan | b_nan) & plain_compare); // RULE17
    wire cond = cm_on ? cmp_flag : iss_pred[n]; // RULE14
    assign sel_val[n] = cond ? a_f : b_f; // RULE11

    if (n % 2 == 0) begin : g_even
      wire [9:0] pair_sad = {1'b0, abs_diff[n]} +
                            {1'b0, abs_diff[n+1]}; // RULE2
      // Guard bits above the destination width absorb 64 rounds.
      assign acc_sum[n] = acc_bus.rdata[n] +
                          {{(ACC_W-10){1'b0}}, pair_sad}; // RULE5
      assign acc_we[n] = is_sada & channel_write_enable_sada[n]; // RULE23
      assign acc_bus.wdata[n] = acc_sum[n]; // RULE4
    end else begin : g_odd
      assign acc_sum[n] = '0;
      assign acc_we[n] = 1'b0;
      assign acc_bus.wdata[n] = acc_bus.rdata[n];
    end

    // Odd words of a pair follow the even enable and carry zero.
    if (n % 2 == 0) begin : g_dst_even
      assign dst_nxt[n] = is_sada ?
        {{(LANE_W-DST_W){1'b0}}, acc_sum[n][DST_W-1:0]} :
        sel_val[n]; // RULE4
      assign we_nxt[n] = is_sada ? channel_write_enable_sada[n] :
                         (is_sel & channel_write_enable_sel[n]); // RULE23
    end else begin : g_dst_odd
      assign dst_nxt[n] = is_sada ? '0 : sel_val[n]; // RULE7
      assign we_nxt[n] = is_sada ? channel_write_enable_sada[n-1] :
                         (is_sel & channel_write_enable_sel[n]); // RULE7
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        res_dst_r[n] <= '0;
      end else if (we_nxt[n]) begin
        res_dst_r[n] <= dst_nxt[n];
      end
    end
    assign res_dst[n*LANE_W +: LANE_W] = res_dst_r[n];
  end

  // ----------------------------------------------------------------------
  // Accumulator bank
  // ----------------------------------------------------------------------
  assign acc_bus.we = acc_we;

  saalu_acc_bank u_acc (
    .clk(clk),
    .rst_n(rst_n),
    .acc(acc_bus.bank)
  );

  // ----------------------------------------------------------------------
  // Result stage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_valid_r <= 1'b0;
      res_we_r <= '0;
    end else begin
      res_valid_r <= is_sada | is_sel;
      res_we_r <= we_nxt;
    end
  end

  assign res_valid = res_valid_r;
  assign res_channel_write_enable = res_we_r;

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // Zero wait states: read data is prepared on the address-phase edge.
  wire ahb_go = hsel & htrans[1] & hready;
  wire dp_wr = ap_wr_r;
  wire wr_ctrl = dp_wr & (ap_addr_r == REG_CTRL);
  wire wr_sel = dp_wr & (ap_addr_r == REG_ACC_SEL);
  wire acc_clr = wr_ctrl & hwdata[CTRL_CLR_BIT];
  wire round_inc = is_sada & (|acc_we);
  wire [REG_AW-1:0] rd_addr = haddr[REG_AW-1:0];
  wire [31:0] status_word = {23'h0, guard_r, round_cnt_r};
  wire [31:0] acc_word = {{(32-ACC_W){1'b0}}, acc_bus.rdata[acc_sel_r]};
  wire [31:0] rd_mux = (rd_addr == REG_CTRL) ? {31'h0, ctrl_en_r} :
                       (rd_addr == REG_STATUS) ? status_word :
                       (rd_addr == REG_ACC_SEL) ?
                         {{(32-ACC_SEL_W){1'b0}}, acc_sel_r} :
                       (rd_addr == REG_ACC_DATA) ? acc_word : 32'h0;
  wire [CNT_W-1:0] cnt_base = acc_clr ? '0 : round_cnt_r;

  assign acc_bus.clr = acc_clr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= '0;
      hrdata_r <= '0;
    end else begin
      ap_wr_r <= ahb_go & hwrite;
      ap_addr_r <= haddr[REG_AW-1:0];
      if (ahb_go & ~hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_en_r <= CTRL_EN_RST;
      acc_sel_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_r <= hwdata[CTRL_EN_BIT];
      end
      if (wr_sel) begin
        acc_sel_r <= hwdata[ACC_SEL_W-1:0];
      end
    end
  end

  // A round landing with a clear counts as the first round after it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      round_cnt_r <= '0;
      guard_r <= 1'b0;
    end else begin
      if (round_inc && cnt_base != {CNT_W{1'b1}}) begin
        round_cnt_r <= cnt_base + 8'h01;
      end else begin
        round_cnt_r <= cnt_base;
      end
      guard_r <= (round_inc & (cnt_base >= 8'(SAD_ROUNDS))) |
                 (guard_r & ~acc_clr);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

endmodule

// [saalu_top_monitor.sv]
/*
  Checker bound to saalu_top; ties each result to the issue before it.
  Assumes one clock and the synchronous active-low reset of the top.
*/
`timescale 1ns/1ns
module saalu_top_monitor
  import saalu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Issue
  input wire logic iss_valid,
  input wire logic [6:0] iss_opcode,
  input wire logic [3:0] iss_cmod,
  input wire logic [ESZ_W-1:0] iss_exec_size,
  input wire logic [2:0] iss_first_source_type,
  input wire logic [NCH*LANE_W-1:0] iss_first_source,
  input wire logic [NCH*LANE_W-1:0] iss_second_source,
  input wire logic [NCH-1:0] iss_chan_en,
  input wire logic iss_pred_on,
  input wire logic [NCH-1:0] iss_pred,
  // Results
  input wire logic res_valid,
  input wire logic [NCH*LANE_W-1:0] res_dst,
  input wire logic [NCH-1:0] res_channel_write_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [NCH*LANE_W-1:0] dst_q;
  logic [NCH-1:0] chg;
  wire [8:0] span = (9'h1 << iss_exec_size) - 9'h1;
  wire [NCH-1:0] lanes = span[NCH-1:0] & iss_chan_en;
  wire [NCH-1:0] sad_en = lanes & (iss_pred_on ? iss_pred : 8'hff);
  wire sad = iss_valid && iss_opcode == OPC_PAIR_SAD_ACC;
  wire sel = iss_valid && iss_opcode == OPC_SELECT;
  wire [31:0] a0 = iss_first_source[31:0];
  wire [31:0] b0 = iss_second_source[31:0];
  wire a0_nan = &a0[30:23] && |a0[22:0];
  wire b0_norm = b0[30:23] != 8'h0 && !(&b0[30:23]);
  wire fl0 = sel && lanes[0] && iss_first_source_type == TY_F && a0_nan && b0_norm;
  always_ff @(posedge clk) dst_q <= res_dst;
  always_comb for (int n = 0; n < NCH; n++) chg[n] =
    res_dst[n*LANE_W +: LANE_W] != dst_q[n*LANE_W +: LANE_W];

  a_result_cause: assert property (
    res_valid |-> $past(sad || sel))
    else $error("Result without a decoded issue.");
  a_other_quiet: assert property (
    iss_valid && !sad && !sel |=> !res_valid)
    else $error("Result for an unknown opcode.");
  a_sel_enable: assert property (sel ##1 res_valid |->
    res_channel_write_enable == $past(lanes))
    else $error("Select enables wrong.");
  a_sad_enable: assert property (sad ##1 res_valid |->
    (res_channel_write_enable & 8'h55) == ($past(sad_en) & 8'h55))
    else $error("Pair SAD enables wrong.");
  a_lanes_hold: assert property (
    (chg & ~(res_valid ? res_channel_write_enable : 8'h0)) == 8'h0)
    else $error("Disabled lane changed.");
  a_sad_width: assert property (sad && sad_en[0] ##1 res_valid |->
    res_dst[31:16] == 16'h0)
    else $error("SAD result too wide.");
  a_pred_pick: assert property (
    sel && lanes[0] && iss_cmod == CMOD_NONE ##1 res_valid |->
    res_dst[31:0] == $past(iss_pred[0] ? a0 : b0))
    else $error("Predicated pick wrong.");
  a_nan_plain: assert property (
    fl0 && iss_cmod == CMOD_EQUAL ##1 res_valid |-> res_dst[31:0] == $past(b0))
    else $error("NaN plain compare wrong.");
  a_nan_aware: assert property (
    fl0 && (iss_cmod == CMOD_LESS || iss_cmod == CMOD_GREATER_EQUAL) ##1
    res_valid |-> res_dst[31:0] == $past(b0))
    else $error("NaN-aware select kept the NaN.");
  cover property (sad ##1 res_valid);
  cover property (fl0 ##1 res_valid);
  cover property (sel && iss_cmod == CMOD_NONE ##1 res_valid);
endmodule

bind saalu_top saalu_top_monitor saalu_top_monitor_inst (.*);

// [saalu_issuer_model.sv]
/*
  Issue-side model: drives one instruction per call, as issue logic would.
  Assumes callers share its clock and call tasks back to back.
*/
`timescale 1ns/1ns
module saalu_issuer_model
  import saalu_pkg::*;
(
  // Clock
  input wire logic clk,
  // Issue lines
  output logic iss_valid,
  output logic [6:0] iss_opcode,
  output logic [3:0] iss_cmod,
  output logic [ESZ_W-1:0] iss_exec_size,
  output logic [2:0] iss_first_source_type,
  output logic [2:0] iss_second_source_type,
  output logic [NCH*LANE_W-1:0] iss_first_source,
  output logic [NCH*LANE_W-1:0] iss_second_source,
  output logic [NCH-1:0] iss_chan_en,
  output logic iss_pred_on,
  output logic [NCH-1:0] iss_pred
);
  initial {iss_valid, iss_opcode, iss_cmod, iss_exec_size, iss_pred_on,
    iss_first_source_type, iss_second_source_type, iss_chan_en, iss_pred, iss_first_source,
    iss_second_source} = '0;
  task automatic issue(input logic [6:0] op, input logic [3:0] cm, esz,
      input logic [2:0] ty, input logic pon, input logic [7:0] pr, ce,
      input logic [255:0] a, b);
    @(posedge clk);
    iss_valid <= 1'b1;
    iss_opcode <= op;
    iss_cmod <= cm;
    iss_exec_size <= (esz < 4'h2) ? 4'h2 : esz;
    iss_first_source_type <= ty;
    iss_second_source_type <= ty;
    iss_first_source <= a;
    iss_second_source <= b;
    iss_chan_en <= ce;
    iss_pred_on <= (op == OPC_SELECT) ? !cm : pon;
    iss_pred <= pr;
  endtask
  // Idle lines change every time, so a stale operand can never match.
  task automatic idle;
    @(posedge clk);
    iss_valid <= 1'b0;
    iss_first_source <= ~iss_first_source;
    iss_second_source <= ~iss_second_source;
    iss_pred <= ~iss_pred;
  endtask
endmodule

// [saalu_top_tb.sv]
/*
  Self-checking bench for saalu_top: bus master, issue model, result queue.
  Assumes the issue model file and the package are compiled first.
*/
`timescale 1ns/1ns
module saalu_top_tb;
  import saalu_pkg::*;
  typedef struct {
    logic [255:0] dst;
    logic [7:0] we, wm, known;
  } saalu_exp_s;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, res_valid, iss_valid, iss_pred_on;
  logic [31:0] hrdata;
  wire hready = hreadyout;
  logic [6:0] iss_opcode;
  logic [3:0] iss_cmod, iss_exec_size;
  logic [2:0] iss_first_source_type, iss_second_source_type;
  logic [255:0] iss_first_source, iss_second_source, res_dst;
  logic [7:0] iss_chan_en, iss_pred, res_channel_write_enable;
  int num_errors = 0, comparisons = 0;
  saalu_exp_s expq[$];
  logic [255:0] shadow = '0;
  logic [7:0] known = 8'hff;
  logic [21:0] acc [NCH] = '{default: 22'h0};
  logic enabled = 1'b1;
  logic [31:0] tbl [NCH] = '{32'h7fc00000, 32'h3f800000, 32'h00000001,
    32'h80000000, 32'hbf800000, 32'h00000000, 32'h807fffff, 32'h7f800000};

  always #5 clk = ~clk;

  saalu_top saalu_top_inst (.*, .hsize(3'h2), .iss_first_source_mod(2'h0),
    .iss_second_source_mod(2'h0));
  saalu_issuer_model saalu_issuer_model_inst (.*);

  task automatic fail(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A read compares its data with d; a write puts d on the bus.
  task automatic bus(input logic w, input logic [3:0] ad,
      input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {28'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    comparisons += !w;
    if (!w && hrdata !== d) fail("read data");
    if (hresp !== 1'b0) fail("hresp");
  endtask
  task automatic chk_res(input saalu_exp_s e);
    comparisons++;
    if ((res_channel_write_enable & e.wm) !== (e.we & e.wm)) fail("enables");
    for (int n = 0; n < NCH; n++) begin
      if (e.known[n] && res_dst[n*32 +: 32] !== e.dst[n*32 +: 32])
        fail("lane");
    end
  endtask
  function automatic logic [9:0] adiff(input logic [7:0] x, y,
      input logic [2:0] t);
    logic [9:0] d;
    d = {{2{t == TY_B && x[7]}}, x} - {{2{t == TY_B && y[7]}}, y};
    return d[9] ? -d : d;
  endfunction
  function automatic logic [31:0] key(input logic [31:0] x, input logic f);
    return !f ? x ^ 32'h80000000 : x[30:0] == 31'h0 ? 32'h80000000 :
      x[31] ? ~x : x | 32'h80000000;
  endfunction
  function automatic logic [31:0] pick(input logic [3:0] c,
      input logic [2:0] t, input logic p, input logic [31:0] a, b);
    logic f, na, nb, r;
    f = t == TY_F;
    if (f && c != CMOD_NONE && a[30:23] == 8'h0) a = {a[31], 31'h0};
    if (f && c != CMOD_NONE && b[30:23] == 8'h0) b = {b[31], 31'h0};
    na = f && &a[30:23] && |a[22:0];
    nb = f && &b[30:23] && |b[22:0];
    case (c)
      CMOD_NONE: r = p;
      CMOD_EQUAL: r = key(a, f) == key(b, f);
      CMOD_NOT_EQUAL: r = key(a, f) != key(b, f);
      CMOD_GREATER: r = key(a, f) > key(b, f);
      CMOD_GREATER_EQUAL: r = key(a, f) >= key(b, f);
      CMOD_LESS: r = key(a, f) < key(b, f);
      CMOD_LESS_EQUAL: r = key(a, f) <= key(b, f);
      default: r = 1'b0;
    endcase
    if (c != CMOD_NONE && (na || nb)) begin
      r = (c == CMOD_GREATER_EQUAL || c == CMOD_LESS) && nb && !na;
    end
    return r ? a : b;
  endfunction
  function automatic logic [255:0] rnd;
    for (int i = 0; i < NCH; i++) rnd[i*32 +: 32] = $urandom;
  endfunction
  task automatic op(input logic [6:0] o, input logic [3:0] c, esz,
      input logic [2:0] t, input logic pon, input logic [7:0] pr, ce,
      input logic [255:0] a, b);
    saalu_exp_s e;
    logic [7:0] em;
    logic [9:0] s;
    em = 8'((9'h1 << esz) - 9'h1);
    e.wm = (o == OPC_SELECT) ? 8'hff : 8'h55;
    e.we = 8'h0;
    if (enabled && (o == OPC_SELECT || o == OPC_PAIR_SAD_ACC)) begin
      for (int n = 0; n < NCH; n++) begin
        if (o == OPC_SELECT && em[n] && ce[n]) begin
          e.we[n] = 1'b1;
          shadow[n*32 +: 32] = pick(c, t, pr[n], a[n*32 +: 32], b[n*32 +: 32]);
          known[n] = 1'b1;
        end
        if (o != OPC_SELECT && !n[0] && em[n] && ce[n] &&
            (!pon || pr[n])) begin
          e.we[n] = 1'b1;
          s = adiff(a[n*32 +: 8], b[n*32 +: 8], t);
          s = s + adiff(a[n*32+32 +: 8], b[n*32+32 +: 8], t);
          acc[n] = acc[n] + 22'(s);
          shadow[n*32 +: 32] = {16'h0, acc[n][15:0]};
          known[n+1] = 1'b0;
        end
      end
      e.dst = shadow;
      e.known = known;
      expq.push_back(e);
    end
    saalu_issuer_model_inst.issue(o, c, esz, t, pon, pr, ce, a, b);
  endtask

  always @(negedge clk) begin
    if (rst_n && res_valid === 1'b1) begin
      if (expq.size() == 0) fail("unexpected result");
      else chk_res(expq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail("watchdog expired");
    tally_and_finish;
  end

  initial begin
    logic [255:0] a, b;
    void'($urandom(32'h7e86));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    bus(1'b0, REG_ACC_DATA, 32'h0);
    repeat (SAD_ROUNDS + 1) op(OPC_PAIR_SAD_ACC, 4'h0, 4'h8, TY_UB, 1'b0,
      8'h0, 8'hff, '1, '0);
    saalu_issuer_model_inst.idle;
    bus(1'b0, REG_STATUS, 32'h141);
    bus(1'b0, REG_ACC_DATA, 32'(acc[0]));
    bus(1'b1, REG_ACC_SEL, 32'hfffffffa);
    bus(1'b0, REG_ACC_SEL, 32'h2);
    bus(1'b1, REG_CTRL, 32'h3);
    foreach (acc[i]) acc[i] = 22'h0;
    bus(1'b0, REG_ACC_DATA, 32'h0);
    repeat (40) op(OPC_PAIR_SAD_ACC, 4'h0, 4'(2 + $urandom % 7),
      ($urandom % 2) ? TY_B : TY_UB, 1'($urandom), 8'($urandom),
      8'($urandom), rnd(), rnd());
    repeat (60) op(OPC_SELECT, 4'($urandom % 7), 4'(2 + $urandom % 7), TY_D,
      1'b0, 8'($urandom), 8'($urandom), rnd(), rnd());
    for (int i = 0; i < 7 * NCH; i++) begin
      for (int n = 0; n < NCH; n++) begin
        a[n*32 +: 32] = tbl[n];
        b[n*32 +: 32] = tbl[(n + i) % NCH];
      end
      op(OPC_SELECT, 4'(i / NCH), 4'h8, TY_F, 1'b0, 8'($urandom), 8'hff, a,
        b);
    end
    saalu_issuer_model_inst.idle;
    bus(1'b0, REG_ACC_DATA, 32'(acc[2]));
    bus(1'b1, REG_CTRL, 32'h0);
    enabled = 1'b0;
    op(OPC_PAIR_SAD_ACC, 4'h0, 4'h8, TY_UB, 1'b0, 8'h0, 8'hff, '1, '0);
    saalu_issuer_model_inst.idle;
    bus(1'b1, REG_CTRL, 32'h1);
    enabled = 1'b1;
    op(7'h50, 4'h0, 4'h8, TY_UB, 1'b0, 8'h0, 8'hff, '1, '0);
    saalu_issuer_model_inst.idle;
    bus(1'b0, REG_ACC_DATA, 32'(acc[2]));
    repeat (3) @(posedge clk);
    if (expq.size() != 0) fail("missing result");
    tally_and_finish;
  end
endmodule
